// ---- src/tfpwm_pkg.sv ----
// package for the thermal fan pwm controller: timing, duty coding, states, carriers
// assumes a single 250 MHz clock; analog comparisons arrive as synchronous flags
//
// How it works
// - one time base clocks states and pwm
// - duty follows higher of two inputs
// - 30% gives 0%, 70% gives full duty
// - power-on performs a full internal reset
// - primary below shutdown threshold shuts down immediately
// - shutdown floats fan drive and fault outputs
// - rise above startup threshold resets like power-up
// - fan start forces drive high 64 periods
// - at power-up drive low, fault inactive
// - primary low at power-up stays in shutdown
// - fault output active-low open-collector
// - fault when primary exceeds overtemperature threshold
// - fault independent of pwm, drive continues
// - fault clears when primary falls back
// - sleep from run only when both inputs below sleep; on leaving shutdown when none above wake
// - sleep floats drive, fault inactive, functions stop
// - wake above threshold, behaves like power-on
// - no fan start unless input above wake
// - shutdown overrides everything, secondary ignored
package tfpwm_pkg;
	// time base: 30 Hz nominal tick at 250 MHz
	localparam int TFPWM_CLK_HZ = 250_000_000;
	localparam int TFPWM_TIMEBASE_HZ = 30;
	localparam int TFPWM_TICK_CYCLES = TFPWM_CLK_HZ / TFPWM_TIMEBASE_HZ;
	// steps of one pwm period; duty code 0..steps means 0..100 %
	localparam int TFPWM_DUTY_STEPS = 64;
	localparam int TFPWM_DUTY_W = 7;
	localparam int TFPWM_STARTUP_PERIODS = 64;
	localparam int TFPWM_START_W = 7;
	localparam logic [TFPWM_DUTY_W-1:0] TFPWM_DUTY_RESET = 7'h00;
	// control code window: 30 % and 70 % of a 255 full-scale code
	localparam int TFPWM_LOW_CODE = 77;
	localparam int TFPWM_HIGH_CODE = 179;

	typedef enum logic [3:0] {
		TFPWM_ST_SHUTDOWN = 4'b0001,
		TFPWM_ST_STARTUP = 4'b0010,
		TFPWM_ST_RUN = 4'b0100,
		TFPWM_ST_SLEEP = 4'b1000
	} tfpwm_state_type;

	// comparator flags, already synchronous to clk
	typedef struct packed {
		logic primary_above_shutdown;
		logic primary_above_startup;
		logic primary_above_overtemp;
		logic primary_below_sleep;
		logic secondary_below_sleep;
		logic primary_above_wake;
		logic secondary_above_wake;
	} tfpwm_cmp_type;

	// pin drive for fan output and fault line
	typedef struct packed {
		logic fan_drive_o;
		logic fan_drive_oe;
		logic overtemp_fault_n_o;
		logic overtemp_fault_n_oe;
	} tfpwm_pins_type;
endpackage

// ---- src/tfpwm_timebase.sv ----
// tfpwm_timebase: divider making a one-cycle tick at the pwm step rate
// assumes clk is the only clock; clear restarts the divider
`timescale 1ns/1ps
module tfpwm_timebase
	import tfpwm_pkg::*;
#(
	parameter int DIVIDE = TFPWM_TICK_CYCLES / TFPWM_DUTY_STEPS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clear,
	output logic step_tick
);
	// refuse a divider too short to make a one-cycle tick
	if (DIVIDE < 2) begin
		$error("tfpwm_timebase: DIVIDE must be at least 2");
	end

	typedef struct packed {
		logic [31:0] count;
		logic tick;
	} tfpwm_tb_state_type;

	tfpwm_tb_state_type st_reg, st_next;

	// free divider; the tick marks one step of the pwm period
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (clear) begin
			st_next.count = 32'h0000_0000;
		end else if (st_reg.count == 32'(DIVIDE - 1)) begin
			st_next.count = 32'h0000_0000;
			st_next.tick = 1'b1;
		end else begin
			st_next.count = st_reg.count + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign step_tick = st_reg.tick;
endmodule

// ---- src/tfpwm_duty_select.sv ----
// tfpwm_duty_select: picks the larger control code and maps it to duty
// assumes codes are linear in supply fraction, full scale = 100 % of supply
`timescale 1ns/1ps
module tfpwm_duty_select
	import tfpwm_pkg::*;
#(
	parameter int CODE_W = 8,
	parameter int LOW_CODE = TFPWM_LOW_CODE,
	parameter int HIGH_CODE = TFPWM_HIGH_CODE
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [CODE_W-1:0] primary_code,
	input wire logic [CODE_W-1:0] secondary_code,
	output logic [TFPWM_DUTY_W-1:0] duty_code
);
	// refuse a window that is empty or does not fit the code width
	if (HIGH_CODE <= LOW_CODE || LOW_CODE < 0 || HIGH_CODE >= (1 << CODE_W)) begin
		$error("tfpwm_duty_select: bad code window");
	end

	typedef struct packed {
		logic [TFPWM_DUTY_W-1:0] duty;
	} tfpwm_ds_state_type;

	tfpwm_ds_state_type st_reg, st_next;

	// clamp below 30 % and above 70 %, linear in between
	function automatic logic [TFPWM_DUTY_W-1:0] map_code(input logic [CODE_W-1:0] c);
		int v;
		v = 0;
		if (int'(c) <= LOW_CODE) v = 0;
		else if (int'(c) >= HIGH_CODE) v = TFPWM_DUTY_STEPS;
		else v = ((int'(c) - LOW_CODE) * TFPWM_DUTY_STEPS) / (HIGH_CODE - LOW_CODE);
		return TFPWM_DUTY_W'(v);
	endfunction

	// higher of the two inputs sets the demand
	always_comb begin
		st_next.duty = (primary_code >= secondary_code) ? map_code(primary_code)
			: map_code(secondary_code);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg.duty <= TFPWM_DUTY_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign duty_code = st_reg.duty;
endmodule

// ---- src/tfpwm_top.sv ----
// tfpwm_top: mode controller and low-frequency pwm for a thermal fan drive
// assumes comparator flags and control codes are synchronous to clk;
// sys_rst stands in for the power-on reset; the pins resolve outside
`timescale 1ns/1ps
module tfpwm_top
	import tfpwm_pkg::*;
#(
	parameter int CODE_W = 8,
	parameter int STEP_DIVIDE = TFPWM_TICK_CYCLES / TFPWM_DUTY_STEPS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire tfpwm_cmp_type cmp,
	input wire logic [CODE_W-1:0] primary_control_input,
	input wire logic [CODE_W-1:0] secondary_control_input,
	output tfpwm_pins_type pins,
	output tfpwm_state_type mode,
	output logic in_shutdown,
	output logic in_sleep,
	output logic in_startup
);
	// the divider cannot make a one-cycle tick below two clocks
	if (STEP_DIVIDE < 2) begin
		$error("tfpwm_top: STEP_DIVIDE too small");
	end

	typedef struct packed {
		tfpwm_state_type state;
		logic [TFPWM_DUTY_W-1:0] phase;
		logic [TFPWM_START_W-1:0] start_periods;
		tfpwm_pins_type pins;
		logic shutdown;
		logic sleep;
		logic startup;
	} tfpwm_top_state_type;

	tfpwm_top_state_type st_reg, st_next;
	logic step_tick;
	logic [TFPWM_DUTY_W-1:0] duty_code;
	logic tb_clear;
	logic wake_req;
	logic sleep_req;

	// time base held still while shut down or asleep
	assign tb_clear = (st_reg.state == TFPWM_ST_SHUTDOWN) || (st_reg.state == TFPWM_ST_SLEEP);

	tfpwm_timebase #(
		.DIVIDE(STEP_DIVIDE)
	) u_timebase (
		.clk(clk),
		.sys_rst(sys_rst),
		.clear(tb_clear),
		.step_tick(step_tick)
	);

	tfpwm_duty_select #(
		.CODE_W(CODE_W)
	) u_duty (
		.clk(clk),
		.sys_rst(sys_rst),
		.primary_code(primary_control_input),
		.secondary_code(secondary_control_input),
		.duty_code(duty_code)
	);

	// grounded sleep threshold leaves the below flags low, so sleep_req never fires
	assign sleep_req = cmp.primary_below_sleep && cmp.secondary_below_sleep;
	assign wake_req = cmp.primary_above_wake || cmp.secondary_above_wake;

	// mode sequencing and pwm
	always_comb begin
		st_next = st_reg;
		case (st_reg.state)
			TFPWM_ST_SHUTDOWN: begin
				// leaving shutdown acts as a fresh power-up
				if (cmp.primary_above_startup) begin
					st_next.state = wake_req ? TFPWM_ST_STARTUP : TFPWM_ST_SLEEP;
					st_next.start_periods = '0;
					st_next.phase = '0;
				end
			end
			TFPWM_ST_SLEEP: begin
				if (wake_req) begin
					st_next.state = TFPWM_ST_STARTUP;
					st_next.start_periods = '0;
					st_next.phase = '0;
				end
			end
			TFPWM_ST_STARTUP: begin
				// count 64 whole periods with drive forced high
				if (step_tick) begin
					st_next.phase = (st_reg.phase == TFPWM_DUTY_W'(TFPWM_DUTY_STEPS - 1))
						? '0 : st_reg.phase + 1'b1;
					if (st_reg.phase == TFPWM_DUTY_W'(TFPWM_DUTY_STEPS - 1)) begin
						st_next.start_periods = st_reg.start_periods + 1'b1;
						if (st_reg.start_periods == TFPWM_START_W'(TFPWM_STARTUP_PERIODS - 1))
							st_next.state = TFPWM_ST_RUN;
					end
				end
			end
			TFPWM_ST_RUN: begin
				if (sleep_req) begin
					st_next.state = TFPWM_ST_SLEEP;
				end else if (step_tick) begin
					// free-running period counter
					st_next.phase = (st_reg.phase == TFPWM_DUTY_W'(TFPWM_DUTY_STEPS - 1))
						? '0 : st_reg.phase + 1'b1;
				end
			end
			default: begin
				st_next.state = TFPWM_ST_SHUTDOWN;
			end
		endcase
		// shutdown wins over every other condition
		if (!cmp.primary_above_shutdown) begin
			st_next.state = TFPWM_ST_SHUTDOWN;
		end

		// output pins from the next state so they track it with no extra lag
		st_next.pins.overtemp_fault_n_o = 1'b0; // open collector only pulls low
		st_next.pins.overtemp_fault_n_oe = 1'b0;
		case (st_next.state)
			TFPWM_ST_SHUTDOWN: begin
				// drive low but released; fault line released
				st_next.pins.fan_drive_o = 1'b0;
				st_next.pins.fan_drive_oe = 1'b0;
			end
			TFPWM_ST_SLEEP: begin
				st_next.pins.fan_drive_o = 1'b0;
				st_next.pins.fan_drive_oe = 1'b0;
			end
			TFPWM_ST_STARTUP: begin
				st_next.pins.fan_drive_o = 1'b1;
				st_next.pins.fan_drive_oe = 1'b1;
				st_next.pins.overtemp_fault_n_oe = cmp.primary_above_overtemp;
			end
			TFPWM_ST_RUN: begin
				// full duty code keeps the output constantly high
				st_next.pins.fan_drive_o = (st_next.phase < duty_code);
				st_next.pins.fan_drive_oe = 1'b1;
				// non-latching, independent of the pwm
				st_next.pins.overtemp_fault_n_oe = cmp.primary_above_overtemp;
			end
			default: begin
				st_next.pins.fan_drive_o = 1'b0;
				st_next.pins.fan_drive_oe = 1'b0;
			end
		endcase
		st_next.shutdown = (st_next.state == TFPWM_ST_SHUTDOWN);
		st_next.sleep = (st_next.state == TFPWM_ST_SLEEP);
		st_next.startup = (st_next.state == TFPWM_ST_STARTUP);
	end

	// reset lands in shutdown with drive low; the comb logic then picks
	// startup, sleep or stays put from the flags, as a power-up would
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg.state <= TFPWM_ST_SHUTDOWN;
			st_reg.phase <= '0;
			st_reg.start_periods <= '0;
			st_reg.pins <= '0;
			st_reg.shutdown <= 1'b1;
			st_reg.sleep <= 1'b0;
			st_reg.startup <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pins = st_reg.pins;
	assign mode = st_reg.state;
	assign in_shutdown = st_reg.shutdown;
	assign in_sleep = st_reg.sleep;
	assign in_startup = st_reg.startup;
endmodule

// ---- dv/tfpwm_properties.sv ----
// checker for tfpwm_top: mode and pin relations at the top ports
// assumes the package code window and two edges from code to pin
`timescale 1ns/1ps
module tfpwm_properties
	import tfpwm_pkg::*;
#(
	parameter int CODE_W = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire tfpwm_cmp_type cmp,
	input wire logic [CODE_W-1:0] primary_control_input,
	input wire logic [CODE_W-1:0] secondary_control_input,
	input wire tfpwm_pins_type pins,
	input wire tfpwm_state_type mode,
	input wire logic in_shutdown,
	input wire logic in_sleep,
	input wire logic in_startup
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic run, wake, on, dry, hi, lo;
	// helper terms; codes are only honoured in run
	assign run = mode == TFPWM_ST_RUN;
	assign on = cmp.primary_above_shutdown;
	assign wake = cmp.primary_above_wake | cmp.secondary_above_wake;
	assign dry = cmp.primary_below_sleep & cmp.secondary_below_sleep;
	assign hi = primary_control_input >= TFPWM_HIGH_CODE || secondary_control_input >= TFPWM_HIGH_CODE;
	assign lo = primary_control_input <= TFPWM_LOW_CODE && secondary_control_input <= TFPWM_LOW_CODE;
	shut_off_a: assert property (!on |=> in_shutdown && pins == 4'h0)
		else $error("shutdown not taken");
	stay_off_a: assert property (in_shutdown && !cmp.primary_above_startup |=> in_shutdown)
		else $error("left shutdown early");
	restart_a: assert property (in_shutdown && on && cmp.primary_above_startup && wake
		|=> in_startup) else $error("no restart");
	start_high_a: assert property (in_startup |-> pins.fan_drive_o && pins.fan_drive_oe)
		else $error("startup drive low");
	sleep_off_a: assert property (in_sleep |-> pins == 4'h0)
		else $error("sleep pins driven");
	wake_up_a: assert property (in_sleep && on && wake |=> in_startup)
		else $error("no wake");
	sleep_in_a: assert property (run && on && dry |=> in_sleep)
		else $error("no sleep");
	run_hold_a: assert property (run && on && !dry |=> run)
		else $error("run left");
	fault_a: assert property ((in_startup || run) ##1 (in_startup || run)
		|-> pins.overtemp_fault_n_oe == $past(cmp.primary_above_overtemp)) else $error("fault");
	fault_low_a: assert property (!pins.overtemp_fault_n_o)
		else $error("fault drives high");
	full_duty_a: assert property ((run && hi)[*3] |-> pins.fan_drive_o && pins.fan_drive_oe)
		else $error("not full duty");
	zero_duty_a: assert property ((run && lo)[*3] |-> !pins.fan_drive_o)
		else $error("not zero duty");
	// main scenarios reached
	cover property ($rose(in_startup));
	cover property (in_sleep ##1 in_startup);
	cover property (run && pins.overtemp_fault_n_oe);
endmodule

// ---- dv/tfpwm_far_model.sv ----
// far side: sensor comparators, fan transistor base, fault pull-up
// assumes codes where 255 is full supply; thresholds are plain defaults
`timescale 1ns/1ps
module tfpwm_far_model
	import tfpwm_pkg::*;
#(
	parameter int SHUT = 15,
	parameter int START = 24,
	parameter int OT = 196,
	parameter int HYST = 28
) (
	input wire logic [7:0] p,
	input wire logic [7:0] s,
	input wire logic [7:0] slp,
	input wire tfpwm_pins_type pins,
	output tfpwm_cmp_type cmp,
	output logic fan_line,
	output logic fault_line_n
);
	// comparators; grounded sleep input never reports below sleep
	assign cmp = {p > SHUT, p > START, p > OT, p < slp, s < slp, p > slp + HYST, s > slp + HYST};
	// base resistor pulls a released drive low; fault line pulled up
	assign fan_line = pins.fan_drive_oe & pins.fan_drive_o;
	assign fault_line_n = pins.overtemp_fault_n_oe ? pins.overtemp_fault_n_o : 1'h1;
endmodule

// ---- dv/tb.sv ----
// testbench for tfpwm_top with far side model and bound checker
// assumes step divide 4: pwm period 256 clocks, startup 16384
`timescale 1ns/1ps
module tb;
	import tfpwm_pkg::*;
	localparam int DIV = 4;
	localparam int PER = 64 * DIV;
	typedef struct {logic [7:0] p; logic [7:0] s; int duty; logic flt;} tfpwm_row_type;
	logic clk = 0;
	logic sys_rst = 1;
	logic [7:0] p = 8'h00;
	logic [7:0] s = 8'h00;
	logic [7:0] slp = 8'h1e;
	tfpwm_cmp_type cmp;
	tfpwm_pins_type pins;
	tfpwm_state_type mode;
	logic in_shutdown, in_sleep, in_startup, fan_line, fault_line_n;
	int n_fail = 0;
	int cmp_count = 0;
	int n, hi;
	// last row: only the secondary input is high, so no fault
	tfpwm_row_type rows[7] = '{'{8'hc8, 8'h00, 64, 1}, '{8'h80, 8'h28, 32, 0},
		'{8'h28, 8'h80, 32, 0}, '{8'hb3, 8'hb3, 64, 0}, '{8'h4d, 8'h3c, 0, 0},
		'{8'hff, 8'hff, 64, 1}, '{8'h80, 8'hff, 64, 0}};
	tfpwm_top #(.CODE_W(8), .STEP_DIVIDE(DIV)) u_dut (.clk(clk), .sys_rst(sys_rst), .cmp(cmp),
		.primary_control_input(p), .secondary_control_input(s), .pins(pins), .mode(mode),
		.in_shutdown(in_shutdown), .in_sleep(in_sleep), .in_startup(in_startup));
	tfpwm_far_model u_far (.p(p), .s(s), .slp(slp), .pins(pins), .cmp(cmp),
		.fan_line(fan_line), .fault_line_n(fault_line_n));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// inputs always move 1 ns after the rising edge
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// bounded wait; a hang is a mismatch and ends the run
	task automatic wait_mode(input tfpwm_state_type m, input int lim);
		for (n = 0; mode !== m && n < lim; n++) begin
			step(1);
		end
		if (mode !== m) begin
			chk("mode", mode, m);
			end_sim();
		end
	endtask
	// high clocks over one whole period, any phase
	task automatic duty();
		hi = 0;
		repeat (PER) begin
			step(1);
			hi += (fan_line === 1'h1);
		end
	endtask
	initial begin
		step(5);
		sys_rst = 0;
		step(20);
		chk("mode", mode, TFPWM_ST_SHUTDOWN);
		chk("pins", pins, 4'h0);
		chk("fault line", fault_line_n, 1'h1);
		p = 8'h80;
		s = 8'h28;
		step(2);
		chk("mode", mode, TFPWM_ST_STARTUP);
		chk("fan line", fan_line, 1'h1);
		chk("startup flag", in_startup, 1'h1);
		wait_mode(TFPWM_ST_RUN, 17000);
		chk("startup clocks", n >= 16100 && n <= 16384, 1'h1);
		$display("test startup done");
		foreach (rows[i]) begin
			p = rows[i].p;
			s = rows[i].s;
			step(4);
			duty();
			chk("high clocks", hi, rows[i].duty * DIV);
			chk("fault line", fault_line_n, !rows[i].flt);
		end
		$display("test duty table done");
		// sleep, then hysteresis: above sleep but under wake stays asleep
		p = 8'h14;
		s = 8'h14;
		step(3);
		chk("mode", mode, TFPWM_ST_SLEEP);
		chk("sleep flag", in_sleep, 1'h1);
		chk("pins", pins, 4'h0);
		p = 8'h32;
		step(20);
		chk("mode", mode, TFPWM_ST_SLEEP);
		s = 8'h46;
		step(2);
		chk("mode", mode, TFPWM_ST_STARTUP);
		$display("test sleep done");
		// shutdown in mid-startup despite a high secondary input
		p = 8'h00;
		s = 8'hff;
		step(2);
		chk("mode", mode, TFPWM_ST_SHUTDOWN);
		chk("shutdown flag", in_shutdown, 1'h1);
		chk("pins", pins, 4'h0);
		p = 8'hc8;
		step(2);
		chk("mode", mode, TFPWM_ST_STARTUP);
		chk("fault line", fault_line_n, 1'h0);
		wait_mode(TFPWM_ST_RUN, 17000);
		$display("test shutdown done");
		slp = 8'h00;
		p = 8'h14;
		s = 8'h14;
		step(PER);
		chk("mode", mode, TFPWM_ST_RUN);
		// reset in mid-run, released with no input above wake
		sys_rst = 1;
		slp = 8'h1e;
		p = 8'h28;
		step(2);
		chk("pins", pins, 4'h0);
		sys_rst = 0;
		step(3);
		chk("mode", mode, TFPWM_ST_SLEEP);
		$display("test reset done");
		end_sim();
	end
endmodule
bind tfpwm_top tfpwm_properties #(.CODE_W(CODE_W)) u_props (.clk(clk), .sys_rst(sys_rst),
	.cmp(cmp), .primary_control_input(primary_control_input),
	.secondary_control_input(secondary_control_input), .pins(pins), .mode(mode),
	.in_shutdown(in_shutdown), .in_sleep(in_sleep), .in_startup(in_startup));
